// ==== common/bsrp_pkg.sv ====
package bsrp_pkg;
    localparam int unsigned BSRP_RAM_DEPTH = 512;
    localparam int unsigned BSRP_PTR_W = 9;
    localparam logic [7:0] BSRP_REG_LAST = 8'h1b;
    localparam logic [7:0] BSRP_REG_WRAP = 8'h00;
    localparam logic [7:0] BSRP_PTR_UPPER_ADDR = 8'h1a;
    localparam logic [7:0] BSRP_PTR_LOWER_ADDR = 8'h1b;
    localparam logic [7:0] BSRP_WRITE_PORT_ADDR = 8'h1c;
    localparam logic [7:0] BSRP_READ_PORT_ADDR = 8'h1d;
    localparam int unsigned BSRP_TOP_BIT_POS = 0;
    localparam logic [8:0] BSRP_PTR_RESET = 9'h000;
    localparam logic [7:0] BSRP_RDATA_RESET = 8'h00;

    // one byte-level event from the serial front end
    typedef struct packed {
        logic sel;
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bsrp_req_type;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } bsrp_rsp_type;
endpackage

// ==== rtl/bsrp_port.sv ====
`timescale 1ns/1ps
// How it works
// RQ1: 512-byte RAM kept while battery powers device
// RQ2: 9-bit pointer, top bit 1Ah, low 1Bh
// RQ3: register pointer auto-increments, wraps 1Bh to 00h
// RQ4: RAM written only via write port 1Ch
// RQ5: RAM read only via read port 1Dh
// RQ6: host loads pointer then streams writes at 1Ch
// RQ7: host loads pointer then streams reads at 1Dh
// RQ8: RAM pointer increments per data byte, wraps
// RQ9: on battery, interface ignored, outputs undriven
module bsrp_port (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // serial front end, byte events
    input bsrp_pkg::bsrp_req_type req,
    output bsrp_pkg::bsrp_rsp_type rsp,
    // power state, asynchronous to sys_clk
    input wire logic on_battery,
    output logic if_out_en,
    // pointer state
    output logic [7:0] reg_ptr,
    output logic [8:0] sram_pointer_full
);
    import bsrp_pkg::*;

    logic [2:0] batt_sync_q;
    logic batt_q;
    logic [7:0] reg_ptr_q;
    logic [8:0] ptr_q;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic oe_q;
    logic ram_we;
    logic [7:0] ram_rdata;
    logic acc;
    logic wr_ok;
    logic rd_ok;
    logic [7:0] reg_next;

    // three stages; change accepted once stages two and three agree
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            batt_sync_q <= 3'h0;
        end else begin
            batt_sync_q <= {batt_sync_q[1:0], on_battery};
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            batt_q <= 1'b0;
        end else if (batt_sync_q[1] == batt_sync_q[2]) begin
            batt_q <= batt_sync_q[2];
        end
    end

    // front end events are gated while on battery
    assign acc = (req.wr | req.rd) & ~batt_q; // [RQ9]
    assign wr_ok = req.wr & ~batt_q;
    assign rd_ok = req.rd & ~batt_q;

    // register pointer: select loads it, each data byte advances it except at ports 1Ch and 1Dh
    assign reg_next = (reg_ptr_q == BSRP_REG_LAST) ? BSRP_REG_WRAP : reg_ptr_q + 8'h01; // [RQ3]

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_ptr_q <= BSRP_REG_WRAP;
        end else if (req.sel & ~batt_q) begin
            reg_ptr_q <= req.addr;
        end else if (acc && reg_ptr_q != BSRP_WRITE_PORT_ADDR && reg_ptr_q != BSRP_READ_PORT_ADDR) begin
            // command ports hold the pointer so a stream stays on RAM
            reg_ptr_q <= reg_next; // [RQ3] [RQ4] [RQ5]
        end
    end

    assign ram_we = wr_ok & (reg_ptr_q == BSRP_WRITE_PORT_ADDR) & ~req.sel; // [RQ4]

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ptr_q <= BSRP_PTR_RESET;
        end else if (~req.sel & wr_ok & (reg_ptr_q == BSRP_PTR_UPPER_ADDR)) begin
            ptr_q[8] <= req.wdata[BSRP_TOP_BIT_POS]; // [RQ2]
        end else if (~req.sel & wr_ok & (reg_ptr_q == BSRP_PTR_LOWER_ADDR)) begin
            ptr_q[7:0] <= req.wdata; // [RQ2]
        end else if (~req.sel & ((wr_ok & reg_ptr_q == BSRP_WRITE_PORT_ADDR)
                     | (rd_ok & reg_ptr_q == BSRP_READ_PORT_ADDR))) begin
            ptr_q <= ptr_q + 9'h001; // [RQ8] 9-bit add wraps 511 to 0
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= BSRP_RDATA_RESET;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= rd_ok & ~req.sel;
            if (rd_ok & ~req.sel) begin
                unique case (reg_ptr_q)
                    BSRP_PTR_UPPER_ADDR: rdata_q <= {7'h00, ptr_q[8]};
                    BSRP_PTR_LOWER_ADDR: rdata_q <= ptr_q[7:0];
                    BSRP_READ_PORT_ADDR: rdata_q <= ram_rdata; // [RQ5]
                    default: rdata_q <= 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= ~batt_q; // [RQ9]
        end
    end

    // memory lives outside the reset domain
    bsrp_sram u_sram (
        .sys_clk(sys_clk),
        .we(ram_we), // [RQ1]
        .addr(ptr_q),
        .wdata(req.wdata),
        .rdata(ram_rdata)
    );

    assign rsp = '{valid: rvalid_q, data: rdata_q};
    assign if_out_en = oe_q;
    assign reg_ptr = reg_ptr_q;
    assign sram_pointer_full = ptr_q;

    // a cycle with no byte event at all
    sequence s_idle;
        !req.sel && !req.wr && !req.rd;
    endsequence

    // one data byte on a command register, select not pending
    sequence s_wport_byte;
        wr_ok && !req.sel && reg_ptr_q == BSRP_WRITE_PORT_ADDR;
    endsequence

    sequence s_rport_byte;
        rd_ok && !req.sel && reg_ptr_q == BSRP_READ_PORT_ADDR;
    endsequence

    // host addresses a command register, then a quiet cycle
    sequence s_sel_wport;
        req.sel && !batt_q && req.addr == BSRP_WRITE_PORT_ADDR ##1 s_idle;
    endsequence

    sequence s_sel_rport;
        req.sel && !batt_q && req.addr == BSRP_READ_PORT_ADDR ##1 s_idle;
    endsequence

    // ram write side
    a_write_addr: assert property (@(posedge sys_clk) disable iff (rst) // [RQ8]
        ram_we |=> ptr_q == $past(ptr_q) + 9'h001)
        else $error("pointer not advanced after write");
    a_write_gate: assert property (@(posedge sys_clk) disable iff (rst) // [RQ4]
        ram_we |-> reg_ptr_q == BSRP_WRITE_PORT_ADDR && !batt_q)
        else $error("ram write off port");
    a_write_entry: assert property (@(posedge sys_clk) disable iff (rst) // [RQ4]
        s_sel_wport ##1 (wr_ok && !req.sel) |-> ram_we)
        else $error("write after port select missed ram");
    a_write_stream: assert property (@(posedge sys_clk) disable iff (rst) // [RQ8]
        s_wport_byte ##1 s_idle ##1 s_wport_byte |=> ptr_q == $past(ptr_q, 3) + 9'h002)
        else $error("write stream pointer wrong");

    // ram read side
    a_read_data: assert property (@(posedge sys_clk) disable iff (rst) // [RQ5]
        rd_ok && !req.sel && reg_ptr_q == BSRP_READ_PORT_ADDR |=> rvalid_q && rdata_q == $past(ram_rdata))
        else $error("read data mismatch");
    a_read_entry: assert property (@(posedge sys_clk) disable iff (rst) // [RQ5]
        s_sel_rport ##1 (rd_ok && !req.sel) |=> rvalid_q && rdata_q == $past(ram_rdata))
        else $error("read after port select not from ram");
    a_read_stream: assert property (@(posedge sys_clk) disable iff (rst) // [RQ8]
        s_rport_byte ##1 s_idle[*2] ##1 s_rport_byte |=> ptr_q == $past(ptr_q, 4) + 9'h002)
        else $error("read stream pointer wrong");
    a_stream_hold: assert property (@(posedge sys_clk) disable iff (rst) // [RQ5]
        acc && !req.sel && reg_ptr_q == BSRP_READ_PORT_ADDR |=> reg_ptr_q == BSRP_READ_PORT_ADDR)
        else $error("stream left read port");
    a_valid_pulse: assert property (@(posedge sys_clk) disable iff (rst) // [RQ5]
        !(rd_ok && !req.sel) |=> !rvalid_q)
        else $error("read valid without read");
    a_data_hold: assert property (@(posedge sys_clk) disable iff (rst) // [RQ5]
        !(rd_ok && !req.sel) |=> $stable(rdata_q))
        else $error("read data moved without read");

    // register and pointer registers
    a_reg_wrap: assert property (@(posedge sys_clk) disable iff (rst) // [RQ3]
        acc && !req.sel && reg_ptr_q == BSRP_REG_LAST |=> reg_ptr_q == BSRP_REG_WRAP)
        else $error("register pointer wrap wrong");
    a_sel_load: assert property (@(posedge sys_clk) disable iff (rst) // [RQ3]
        req.sel && !batt_q |=> reg_ptr_q == $past(req.addr))
        else $error("register select not taken");
    a_upper_load: assert property (@(posedge sys_clk) disable iff (rst) // [RQ2]
        wr_ok && !req.sel && reg_ptr_q == BSRP_PTR_UPPER_ADDR |=> ptr_q[8] == $past(req.wdata[0])
        && reg_ptr_q == BSRP_PTR_LOWER_ADDR) else $error("upper pointer load wrong");
    a_lower_load: assert property (@(posedge sys_clk) disable iff (rst) // [RQ2]
        wr_ok && !req.sel && reg_ptr_q == BSRP_PTR_LOWER_ADDR |=> ptr_q[7:0] == $past(req.wdata))
        else $error("lower pointer load wrong");
    a_upper_read: assert property (@(posedge sys_clk) disable iff (rst) // [RQ2]
        rd_ok && !req.sel && reg_ptr_q == BSRP_PTR_UPPER_ADDR |=> rdata_q == {7'h00, $past(ptr_q[8])})
        else $error("upper pointer read back wrong");
    a_lower_read: assert property (@(posedge sys_clk) disable iff (rst) // [RQ2]
        rd_ok && !req.sel && reg_ptr_q == BSRP_PTR_LOWER_ADDR |=> rdata_q == $past(ptr_q[7:0]))
        else $error("lower pointer read back wrong");

    // battery lockout
    a_batt_settle: assert property (@(posedge sys_clk) disable iff (rst) // [RQ9]
        batt_sync_q[1] == batt_sync_q[2] |=> batt_q == $past(batt_sync_q[2]))
        else $error("settled battery level not taken");
    a_batt_hold: assert property (@(posedge sys_clk) disable iff (rst) // [RQ9]
        batt_sync_q[1] != batt_sync_q[2] |=> $stable(batt_q))
        else $error("battery state moved while unsettled");
    a_batt_frozen: assert property (@(posedge sys_clk) disable iff (rst) // [RQ9]
        batt_q ##1 batt_q |-> $stable(ptr_q) && $stable(reg_ptr_q) && !if_out_en)
        else $error("state changed on battery");
    a_oe_off: assert property (@(posedge sys_clk) disable iff (rst) // [RQ9]
        batt_q |=> !if_out_en)
        else $error("outputs driven on battery");
    a_oe_on: assert property (@(posedge sys_clk) disable iff (rst) // [RQ9]
        !batt_q |=> if_out_en)
        else $error("outputs not driven on main supply");
endmodule

// ==== rtl/bsrp_sram.sv ====
`timescale 1ns/1ps
module bsrp_sram (
    // clock
    input wire logic sys_clk,
    // port
    input wire logic we,
    input wire logic [8:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    import bsrp_pkg::*;
    // array has no reset: contents must survive controller reset
    logic [7:0] mem [0:BSRP_RAM_DEPTH-1];

    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    assign rdata = mem[addr];

    a_cell_kept: assert property (@(posedge sys_clk) we |=> mem[$past(addr)] == $past(wdata)) // [RQ1]
        else $error("ram cell not written");
endmodule

// ==== verif/bsrp_host.sv ====
`timescale 1ns/1ps
module bsrp_host (
    // clock
    input wire logic sys_clk,
    // byte events toward the device
    output bsrp_pkg::bsrp_req_type req
);
    import bsrp_pkg::*;
    initial req = '0;
    // idle fields flip so a stale byte is never mistaken for a live one
    task automatic put(input logic s, input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        req <= '{sel: s, wr: w, rd: r, addr: a, wdata: d};
        @(negedge sys_clk);
        req <= '{sel: 1'b0, wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic set_ptr(input logic [8:0] p);
        put(1'b1, 1'b0, 1'b0, BSRP_PTR_UPPER_ADDR, 8'h00);
        put(1'b0, 1'b1, 1'b0, 8'h00, {7'h00, p[8]});
        put(1'b0, 1'b1, 1'b0, 8'h00, p[7:0]);
    endtask
endmodule

// ==== verif/test_backed_sram_register_port.sv ====
`timescale 1ns/1ps
module test_backed_sram_register_port;
    import bsrp_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic on_battery = 1'b0;
    bsrp_req_type req;
    bsrp_rsp_type rsp;
    logic if_out_en;
    logic [7:0] reg_ptr;
    logic [8:0] sram_pointer_full;
    int err_total = 0;
    int compares = 0;
    bsrp_host host (.sys_clk(sys_clk), .req(req));
    bsrp_port dut (.sys_clk(sys_clk), .rst(rst), .req(req), .rsp(rsp), .on_battery(on_battery),
        .if_out_en(if_out_en), .reg_ptr(reg_ptr), .sram_pointer_full(sram_pointer_full));
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        if (err_total == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // valid stands one cycle only, so it is looked at then and once after
    task automatic rd_byte(output logic [7:0] d);
        host.put(1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
        chk_bit(rsp.valid, 1'b1);
        d = rsp.data;
        @(negedge sys_clk);
        chk_bit(rsp.valid, 1'b0);
    endtask
    initial begin
        logic [7:0] d;
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        chk_byte(reg_ptr, BSRP_REG_WRAP);
        chk(sram_pointer_full, BSRP_PTR_RESET);
        chk_bit(if_out_en, 1'b1);
        chk_bit(rsp.valid, 1'b0);
        host.set_ptr(9'h1ff);
        chk(sram_pointer_full, 9'h1ff);
        chk_byte(reg_ptr, BSRP_REG_WRAP);
        host.put(1'b1, 1'b0, 1'b0, BSRP_WRITE_PORT_ADDR, 8'h00);
        host.put(1'b0, 1'b1, 1'b0, 8'h00, 8'ha5);
        host.put(1'b0, 1'b1, 1'b0, 8'h00, 8'h3c);
        chk(sram_pointer_full, 9'h001);
        chk_byte(reg_ptr, BSRP_WRITE_PORT_ADDR);
        host.put(1'b1, 1'b0, 1'b0, BSRP_PTR_UPPER_ADDR, 8'h00);
        host.put(1'b0, 1'b1, 1'b0, 8'h00, 8'h01);
        chk_byte(reg_ptr, BSRP_PTR_LOWER_ADDR);
        host.put(1'b0, 1'b1, 1'b0, 8'h00, 8'hff);
        chk(sram_pointer_full, 9'h1ff);
        // pointer registers read back what was loaded
        host.put(1'b1, 1'b0, 1'b0, BSRP_PTR_UPPER_ADDR, 8'h00);
        rd_byte(d);
        chk_byte(d, 8'h01);
        rd_byte(d);
        chk_byte(d, 8'hff);
        chk_byte(reg_ptr, BSRP_REG_WRAP);
        host.put(1'b1, 1'b0, 1'b0, BSRP_READ_PORT_ADDR, 8'h00);
        rd_byte(d);
        chk_byte(d, 8'ha5);
        rd_byte(d);
        chk_byte(d, 8'h3c);
        chk(sram_pointer_full, 9'h001);
        chk_byte(reg_ptr, BSRP_READ_PORT_ADDR);
        on_battery = 1'b1;
        repeat (6) @(negedge sys_clk);
        chk_bit(if_out_en, 1'b0);
        host.set_ptr(9'h0a5);
        host.put(1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
        chk_bit(rsp.valid, 1'b0);
        chk(sram_pointer_full, 9'h001);
        chk_byte(reg_ptr, BSRP_READ_PORT_ADDR);
        on_battery = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk_bit(if_out_en, 1'b1);
        host.set_ptr(9'h000);
        // a byte outside the write port must not reach the ram
        host.put(1'b0, 1'b1, 1'b0, 8'h00, 8'h77);
        chk(sram_pointer_full, 9'h000);
        host.put(1'b1, 1'b0, 1'b0, BSRP_READ_PORT_ADDR, 8'h00);
        rd_byte(d);
        chk_byte(d, 8'h3c);
        // controller reset mid-run leaves ram contents alone
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        chk(sram_pointer_full, BSRP_PTR_RESET);
        chk_byte(reg_ptr, BSRP_REG_WRAP);
        chk_byte(rsp.data, BSRP_RDATA_RESET);
        chk_bit(if_out_en, 1'b1);
        host.put(1'b1, 1'b0, 1'b0, BSRP_READ_PORT_ADDR, 8'h00);
        rd_byte(d);
        chk_byte(d, 8'h3c);
        close_out();
    end
    initial begin
        #(3000 * 100);
        err_total++;
        close_out();
    end
endmodule
